// File: rdpg_pkg.sv
// Shared constants for the discharge select and output 3 delay registers
package rdpg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_DISCH_SECOND = 8'h41;
  localparam logic [7:0] ADDR_DISCH_THIRD  = 8'h42;
  localparam logic [7:0] ADDR_GOOD_DELAY   = 8'h43;

  // ****************************************
  // Reset values (one factory variant)
  // ****************************************
  localparam logic [7:0] RST_DISCH_SECOND  = 8'h55;
  localparam logic [7:0] RST_DISCH_THIRD   = 8'h15;
  localparam logic [2:0] RST_DELAY_CODE    = 3'h6;

  // ****************************************
  // Rails and field layout
  // ****************************************
  // Rail index i owns discharge bits [2i+1:2i] of the flat vector;
  // indices 0..3 live in the second register, 4..6 in the third
  localparam int unsigned NUM_RAILS        = 7;
  localparam int unsigned RAIL_CONV_FIVE   = 0;
  localparam int unsigned RAIL_CONV_SIX    = 1;
  localparam int unsigned RAIL_SWITCH_A1   = 2;
  localparam int unsigned RAIL_LINREG_TWO  = 3;
  localparam int unsigned RAIL_LINREG_THR  = 4;
  localparam int unsigned RAIL_SWITCH_B1   = 5;
  localparam int unsigned RAIL_SWITCH_B2   = 6;
  localparam int unsigned SECOND_RAILS     = 4;
  localparam int unsigned FIELD_W          = 2;
  localparam int unsigned DELAY_LSB        = 0;
  localparam int unsigned DELAY_W          = 3;
  localparam logic [1:0]  DISCH_OFF        = 2'h0;
  localparam logic [1:0]  DISCH_100_OHM    = 2'h1;
  localparam logic [1:0]  DISCH_200_OHM    = 2'h2;
  localparam logic [1:0]  DISCH_500_OHM    = 2'h3;

  // ****************************************
  // Output 3 source modes
  // ****************************************
  localparam logic [1:0] MODE_POWER_GOOD   = 2'h0;
  localparam logic [1:0] MODE_LEVEL_SHIFT  = 2'h1;
  localparam logic [1:0] MODE_SERIAL       = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned CLK_PER_US       = 1000 / CLK_PERIOD_NS;
  localparam int unsigned DELAY_BASE_US    = 2500;
  localparam int unsigned DELAY_BASE_CYCLES = DELAY_BASE_US * CLK_PER_US;
  localparam int unsigned DELAY0_US        = 2500;
  localparam int unsigned DELAY1_US        = 5000;
  localparam int unsigned DELAY2_US        = 10000;
  localparam int unsigned DELAY3_US        = 15000;
  localparam int unsigned DELAY4_US        = 20000;
  localparam int unsigned DELAY5_US        = 50000;
  localparam int unsigned DELAY6_US        = 75000;
  localparam int unsigned DELAY7_US        = 100000;
  localparam int unsigned TICK_W           = 6;

  // Delay length in base ticks for a delay code
  function automatic logic [TICK_W-1:0] delay_ticks(input logic [2:0] code);
    int unsigned us;
    us = DELAY0_US;
    case (code)
      3'h0:    us = DELAY0_US;
      3'h1:    us = DELAY1_US;
      3'h2:    us = DELAY2_US;
      3'h3:    us = DELAY3_US;
      3'h4:    us = DELAY4_US;
      3'h5:    us = DELAY5_US;
      3'h6:    us = DELAY6_US;
      default: us = DELAY7_US;
    endcase
    return TICK_W'(us / DELAY_BASE_US);
  endfunction

endpackage

// File: rdpg_delay_timer.sv
// Power-good delay timer counted in coarse base ticks
`timescale 1ns/1ps
module rdpg_delay_timer #(
  parameter int unsigned BASE_CYCLES = rdpg_pkg::DELAY_BASE_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        clkEn,
  input  wire logic                        start,
  input  wire logic [rdpg_pkg::TICK_W-1:0] ticks,
  output logic                             done
);

  localparam int unsigned CW = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(BASE_CYCLES - 1);

  if (BASE_CYCLES < 1) begin : g_bad_base
    $error("BASE_CYCLES must be at least 1");
  end

  typedef enum logic [1:0] {T_IDLE, T_RUN, T_DONE} rdpg_tstate_e;

  typedef struct packed {
    rdpg_tstate_e                state;
    logic [CW-1:0]               cyc;
    logic [rdpg_pkg::TICK_W-1:0] left;
  } rdpg_timer_s;

  rdpg_timer_s s_r;
  rdpg_timer_s s_nxt;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      T_IDLE: begin
        if (start) begin
          s_nxt.state = T_RUN;
          s_nxt.cyc   = '0;
          s_nxt.left  = ticks;
        end
      end
      T_RUN: begin
        if (!start) begin
          s_nxt.state = T_IDLE;
        end else if (s_r.cyc == LAST) begin
          s_nxt.cyc = '0;
          if (s_r.left <= rdpg_pkg::TICK_W'(1)) begin
            s_nxt.state = T_DONE;
          end else begin
            s_nxt.left = rdpg_pkg::TICK_W'(s_r.left - 1'b1);
          end
        end else begin
          s_nxt.cyc = CW'(s_r.cyc + 1'b1);
        end
      end
      T_DONE: begin
        if (!start) begin
          s_nxt.state = T_IDLE;
        end
      end
      default: s_nxt.state = T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{state: T_IDLE, cyc: '0, left: '0};
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  assign done = (s_r.state == T_DONE);

endmodule

// File: rdpg_regs.sv
// Discharge select registers and output 3 power-good delay
//
// What this block does
// - Each 2-bit discharge field picks off, 100, 200 or 500 ohms.
// - A field reads and acts as 00 whenever its rail is enabled.
// - Offset 41h holds linreg two, switch A1, converter six, five.
// - Offset 42h holds switch B2, B1 and linreg three; 7:6 read zero.
// - Offset 43h holds the 3-bit delay code in 2:0; 7:3 read zero.
// - The delay code selects 2.5 to 100 ms from a fixed table.
// - In power good mode timing starts once all grouped rails regulate; then output 3 rises.
// - The delay may be off by ten percent, so a coarse tick is used.
// - Under serial control without termination use the delay is unused.
// - Output 3 is power good, level shifter or serial-driven.
`timescale 1ns/1ps
module rdpg_regs #(
  parameter int unsigned          GROUP_W     = 7,
  parameter int unsigned          BASE_CYCLES = rdpg_pkg::DELAY_BASE_CYCLES,
  parameter logic [7:0]           RST_SECOND  = rdpg_pkg::RST_DISCH_SECOND,
  parameter logic [7:0]           RST_THIRD   = rdpg_pkg::RST_DISCH_THIRD,
  parameter logic [2:0]           RST_DELAY   = rdpg_pkg::RST_DELAY_CODE
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWrData,
  output logic      [7:0]           regRdData,
  input  wire logic [6:0]           railEnable,
  input  wire logic [GROUP_W-1:0]   railInReg,
  input  wire logic                 levelIn,
  input  wire logic [1:0]           gpo3Mode,
  input  wire logic                 vttUse,
  input  wire logic                 serialLevel,
  output logic      [7:0]           dischargeSecond,
  output logic      [5:0]           dischargeThird,
  output logic                      generalOutputThree,
  output logic                      vttEnable
);

  localparam int unsigned NR = rdpg_pkg::NUM_RAILS;
  localparam int unsigned FW = rdpg_pkg::FIELD_W;
  localparam int unsigned S2 = rdpg_pkg::SECOND_RAILS;

  if (GROUP_W < 1) begin : g_bad_group
    $error("GROUP_W must be at least 1");
  end
  if (BASE_CYCLES < 1) begin : g_bad_base
    $error("BASE_CYCLES must be at least 1");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NR-1:0]      enMeta;
    logic [NR-1:0]      enSync;
    logic [GROUP_W-1:0] goodMeta;
    logic [GROUP_W-1:0] goodSync;
    logic               levelMeta;
    logic               levelSync;
    logic [NR*FW-1:0]   disch;
    logic [2:0]         delayCode;
    logic [7:0]         rdData;
    logic               general_output_three;
    logic               vtt;
  } rdpg_state_s;

  rdpg_state_s s_r;
  rdpg_state_s s_nxt;

  logic       groupGood;
  logic       timerStart;
  logic       timerDone;
  logic       delayUsed;
  logic [7:0] secondView;
  logic [7:0] thirdView;
  logic [7:0] delayView;

  assign groupGood = &s_r.goodSync;

  // Level shifting times the shifted input; power good, and the other modes only while vttUse is set, time the rails
  always_comb begin
    delayUsed  = 1'b0;
    timerStart = 1'b0;
    case (gpo3Mode)
      rdpg_pkg::MODE_POWER_GOOD: begin
        delayUsed  = 1'b1;
        timerStart = groupGood;
      end
      rdpg_pkg::MODE_LEVEL_SHIFT: begin
        delayUsed  = 1'b1;
        timerStart = s_r.levelSync;
      end
      default: begin
        delayUsed  = vttUse;
        timerStart = vttUse & groupGood;
      end
    endcase
  end

  // ****************************************
  // Register views
  // ****************************************
  assign secondView = s_r.disch[S2*FW-1:0];
  assign thirdView  = {2'h0, s_r.disch[NR*FW-1:S2*FW]};
  assign delayView  = {5'h00, s_r.delayCode};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic wrSecond;
    logic wrThird;
    logic [7:0] wrField;
    wrSecond = regWrEn && (regAddr == rdpg_pkg::ADDR_DISCH_SECOND);
    wrThird  = regWrEn && (regAddr == rdpg_pkg::ADDR_DISCH_THIRD);
    wrField  = 8'h00;
    s_nxt    = s_r;

    s_nxt.enMeta    = railEnable;
    s_nxt.enSync    = s_r.enMeta;
    s_nxt.goodMeta  = railInReg;
    s_nxt.goodSync  = s_r.goodMeta;
    s_nxt.levelMeta = levelIn;
    s_nxt.levelSync = s_r.levelMeta;

    for (int i = 0; i < NR; i++) begin
      wrField = (i < S2) ? regWrData : {2'h0, regWrData[5:0]};
      if (s_r.enSync[i]) begin
        s_nxt.disch[i*FW +: FW] = rdpg_pkg::DISCH_OFF;
      end else if ((i < S2) ? wrSecond : wrThird) begin
        s_nxt.disch[i*FW +: FW] = wrField[(i % S2)*FW +: FW];
      end
    end

    if (regWrEn && (regAddr == rdpg_pkg::ADDR_GOOD_DELAY)) begin
      s_nxt.delayCode =
        regWrData[rdpg_pkg::DELAY_LSB +: rdpg_pkg::DELAY_W];
    end

    if (regRdEn) begin
      case (regAddr)
        rdpg_pkg::ADDR_DISCH_SECOND: s_nxt.rdData = secondView;
        rdpg_pkg::ADDR_DISCH_THIRD:  s_nxt.rdData = thirdView;
        rdpg_pkg::ADDR_GOOD_DELAY:   s_nxt.rdData = delayView;
        default:                     s_nxt.rdData = 8'h00;
      endcase
    end

    // Output drops at once when its cause goes away
    if (gpo3Mode == rdpg_pkg::MODE_SERIAL) begin
      s_nxt.general_output_three = serialLevel;
    end else begin
      s_nxt.general_output_three = delayUsed & timerStart & timerDone;
    end
    s_nxt.vtt = vttUse & groupGood & timerDone;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{enMeta:    '0,
               enSync:    '0,
               goodMeta:  '0,
               goodSync:  '0,
               levelMeta: 1'b0,
               levelSync: 1'b0,
               disch:     {RST_THIRD[5:0], RST_SECOND},
               delayCode: RST_DELAY,
               rdData:    8'h00,
               general_output_three:      1'b0,
               vtt:       1'b0};
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Delay timer
  // ****************************************
  rdpg_delay_timer #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .start (timerStart),
    .ticks (rdpg_pkg::delay_ticks(s_r.delayCode)),
    .done  (timerDone)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdData          = s_r.rdData;
  assign dischargeSecond    = s_r.disch[S2*FW-1:0];
  assign dischargeThird     = s_r.disch[NR*FW-1:S2*FW];
  assign generalOutputThree = s_r.general_output_three;
  assign vttEnable          = s_r.vtt;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_force_conv_five: assert property (
    (clkEn && s_r.enSync[rdpg_pkg::RAIL_CONV_FIVE])
      |=> dischargeSecond[1:0] == rdpg_pkg::DISCH_OFF)
    else $error("Converter five discharge not forced off");

  a_force_linreg_three: assert property (
    (clkEn && s_r.enSync[rdpg_pkg::RAIL_LINREG_THR])
      |=> dischargeThird[1:0] == rdpg_pkg::DISCH_OFF)
    else $error("Linreg three discharge not forced off");

  a_write_second_reg: assert property (
    (clkEn && regWrEn && regAddr == rdpg_pkg::ADDR_DISCH_SECOND &&
     s_r.enSync[S2-1:0] == '0)
      |=> dischargeSecond == $past(regWrData))
    else $error("Second discharge write not stored");

  a_third_resv_zero: assert property (
    (clkEn && regRdEn && regAddr == rdpg_pkg::ADDR_DISCH_THIRD)
      |=> regRdData[7:6] == 2'h0 &&
          regRdData[5:0] == $past(dischargeThird))
    else $error("Third register read wrong");

  a_delay_resv_zero: assert property (
    (clkEn && regWrEn && regAddr == rdpg_pkg::ADDR_GOOD_DELAY) ##1
    (clkEn && regRdEn && regAddr == rdpg_pkg::ADDR_GOOD_DELAY)
      |=> regRdData == {5'h00, $past(regWrData[2:0], 2)})
    else $error("Delay register read back wrong");

  a_pg_drops_fast: assert property (
    (clkEn && gpo3Mode == rdpg_pkg::MODE_POWER_GOOD && !groupGood)
      |=> !generalOutputThree)
    else $error("Output 3 high while grouped rails not good");

  a_pg_needs_delay: assert property (
    ($rose(generalOutputThree) &&
     $past(gpo3Mode) == rdpg_pkg::MODE_POWER_GOOD)
      |-> $past(timerDone) && $past(groupGood))
    else $error("Output 3 rose before delay expired");

  a_serial_follows: assert property (
    (clkEn && gpo3Mode == rdpg_pkg::MODE_SERIAL)
      |=> generalOutputThree == $past(serialLevel))
    else $error("Serial-driven output 3 does not follow");

  a_unmapped_zero: assert property (
    (clkEn && regRdEn && regAddr != rdpg_pkg::ADDR_DISCH_SECOND &&
     regAddr != rdpg_pkg::ADDR_DISCH_THIRD &&
     regAddr != rdpg_pkg::ADDR_GOOD_DELAY)
      |=> regRdData == 8'h00)
    else $error("Unmapped read not zero");

  a_force_conv_six: assert property (
    (clkEn && s_r.enSync[rdpg_pkg::RAIL_CONV_SIX])
      |=> dischargeSecond[3:2] == rdpg_pkg::DISCH_OFF)
    else $error("Converter six discharge not forced off");

  a_force_switch_a1: assert property (
    (clkEn && s_r.enSync[rdpg_pkg::RAIL_SWITCH_A1])
      |=> dischargeSecond[5:4] == rdpg_pkg::DISCH_OFF)
    else $error("Switch A1 discharge not forced off");

  a_force_linreg_two: assert property (
    (clkEn && s_r.enSync[rdpg_pkg::RAIL_LINREG_TWO])
      |=> dischargeSecond[7:6] == rdpg_pkg::DISCH_OFF)
    else $error("Linreg two discharge not forced off");

  a_force_switch_b1: assert property (
    (clkEn && s_r.enSync[rdpg_pkg::RAIL_SWITCH_B1])
      |=> dischargeThird[3:2] == rdpg_pkg::DISCH_OFF)
    else $error("Switch B1 discharge not forced off");

  a_force_switch_b2: assert property (
    (clkEn && s_r.enSync[rdpg_pkg::RAIL_SWITCH_B2])
      |=> dischargeThird[5:4] == rdpg_pkg::DISCH_OFF)
    else $error("Switch B2 discharge not forced off");

  a_write_third_reg: assert property (
    (clkEn && regWrEn && regAddr == rdpg_pkg::ADDR_DISCH_THIRD &&
     s_r.enSync[NR-1:S2] == '0)
      |=> dischargeThird == $past(regWrData[5:0]))
    else $error("Third discharge write not stored");

  a_second_read_back: assert property (
    (clkEn && regRdEn && regAddr == rdpg_pkg::ADDR_DISCH_SECOND)
      |=> regRdData == $past(dischargeSecond))
    else $error("Second register read wrong");

  a_delay_code_store: assert property (
    (clkEn && regWrEn && regAddr == rdpg_pkg::ADDR_GOOD_DELAY)
      |=> s_r.delayCode == $past(regWrData[2:0]))
    else $error("Delay code write not stored");

  a_vtt_needs_good: assert property (
    (clkEn && !groupGood) |=> !vttEnable)
    else $error("Termination enable high while rails not good");

endmodule

// File: rdpg_host_model.sv
// Host model driving the register strobes of the block
`timescale 1ns/1ps
module rdpg_host_model (
  input  wire logic       clk,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // Released address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn   <= 1'b0;
    regAddr   <= ~a;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask

  // Write, then read the same offset in the very next cycle
  task automatic wrRd(input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn   <= 1'b0;
    regRdEn   <= 1'b1;
    regWrData <= ~d;
    @(posedge clk);
    regRdEn   <= 1'b0;
    regAddr   <= ~a;
    #1;
    q = regRdData;
  endtask
endmodule

// File: tb_top.sv
// Self-checking testbench for the discharge and delay registers
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned BASE = 4;
  localparam int unsigned GRP  = 2;
  logic           clk, rst, clkEn, levelIn, vttUse, serialLevel;
  logic           regWrEn, regRdEn, generalOutputThree, vttEnable;
  logic [7:0]     regAddr, regWrData, regRdData, dischargeSecond, rdv;
  logic [6:0]     railEnable;
  logic [GRP-1:0] railInReg;
  logic [1:0]     gpo3Mode;
  logic [5:0]     dischargeThird;
  int             err_count, tests_run, k, c, mdl[2:0];
  int             tickQ[$] = '{1, 2, 4, 6, 8, 20, 30, 40};

  rdpg_regs #(.GROUP_W(GRP), .BASE_CYCLES(BASE)) rdpg_regs_inst (
    .clk(clk), .rst(rst), .clkEn(clkEn), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .railEnable(railEnable),
    .railInReg(railInReg), .levelIn(levelIn), .gpo3Mode(gpo3Mode),
    .vttUse(vttUse), .serialLevel(serialLevel),
    .dischargeSecond(dischargeSecond), .dischargeThird(dischargeThird),
    .generalOutputThree(generalOutputThree), .vttEnable(vttEnable));

  rdpg_host_model rdpg_host_model_inst (
    .clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Reference model and checks
  // ****************************************
  function automatic int mdlRd(int a);
    if (a >= 'h41 && a <= 'h43) return mdl[a-'h41];
    return 0;
  endfunction

  // Enabled rails hold their field at zero, whatever was written
  function automatic void mdlForce(logic [6:0] en);
    for (int i = 0; i < 7; i++) begin
      if (en[i]) mdl[i/4] &= ~(3 << (2*(i%4)));
    end
  endfunction

  function automatic void mdlWr(int a, int d, logic [6:0] en);
    int m;
    m = (a == 'h43) ? 'h07 : (a == 'h42) ? 'h3f : 'hff;
    if (a >= 'h41 && a <= 'h43) mdl[a-'h41] = d & m;
    mdlForce(en);
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkRd(input int a);
    rdpg_host_model_inst.rd(8'(a), rdv);
    chk("regRdData", 8'(mdlRd(a)), rdv);
    chk("dischargeSecond", 8'(mdl[0]), dischargeSecond);
    chk("dischargeThird", 8'(mdl[1]), {2'b00, dischargeThird});
  endtask

  task automatic wrChk(input int a, input int d);
    rdpg_host_model_inst.wr(8'(a), 8'(d));
    mdlWr(a, d, railEnable);
    chkRd(a);
  endtask

  // Write and read back on consecutive cycles
  task automatic wrRdChk(input int a, input int d);
    rdpg_host_model_inst.wrRd(8'(a), 8'(d), rdv);
    mdlWr(a, d, railEnable);
    chk("backToBack", 8'(mdlRd(a)), rdv);
    chkRd(a);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Time from the timing source rising to the selected output rising
  task automatic measure(input bit vtt, input bit lvl, input int ticks);
    int e;
    e = ticks * BASE + 4;
    @(posedge clk);
    if (lvl) levelIn <= 1'b1;
    else railInReg <= '1;
    c = 0;
    while ((vtt ? vttEnable : generalOutputThree) !== 1'b1) begin
      @(posedge clk);
      #1;
      c++;
      if (c > e + 10) begin
        err_count++;
        $display("[ERR] outputRise expected %0d seen none", e);
        tally_and_finish();
      end
    end
    chk("riseInWindow", 8'h01, 8'(c >= e - 2 && c <= e + 2));
    @(posedge clk);
    railInReg <= '0;
    levelIn <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("fallAfterLoss", 8'h00, 8'(vtt ? vttEnable : generalOutputThree));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    railEnable = '0;
    railInReg = '0;
    levelIn = 1'b0;
    gpo3Mode = 2'h0;
    vttUse = 1'b0;
    serialLevel = 1'b0;
    err_count = 0;
    tests_run = 0;
    mdl = '{'h06, 'h15, 'h55};
    void'($urandom(32'h50e4));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (k = 'h41; k <= 'h44; k++) chkRd(k);
    for (k = 0; k < 4; k++) begin
      wrChk('h41, {4{2'(k)}});
      wrChk('h42, {4{2'(k)}});
    end
    repeat (12) wrChk('h41 + $urandom % 4, $urandom);
    clkEn <= 1'b0;
    rdpg_host_model_inst.wr(8'h43, 8'h05);
    clkEn <= 1'b1;
    chkRd('h43);
    railEnable <= 7'($urandom) | 7'h11;
    repeat (4) @(posedge clk);
    mdlForce(railEnable);
    chkRd('h41);
    wrChk('h41, 'hff);
    wrChk('h42, 'hff);
    railEnable <= '0;
    repeat (4) @(posedge clk);
    chkRd('h42);
    railInReg <= 2'b01;
    repeat (30) @(posedge clk);
    #1;
    chk("partialGroup", 8'h00, 8'(generalOutputThree));
    railInReg <= '0;
    for (k = 0; k < 8; k++) begin
      wrRdChk('h43, ($urandom & 'hf8) | k);
      measure(1'b0, 1'b0, tickQ[k]);
    end
    gpo3Mode <= 2'h1;
    wrChk('h43, 2);
    measure(1'b0, 1'b1, tickQ[2]);
    gpo3Mode <= 2'h2;
    repeat (6) begin
      @(posedge clk);
      serialLevel <= 1'($urandom);
      @(posedge clk);
      #1;
      chk("serialOut", 8'(serialLevel), 8'(generalOutputThree));
    end
    vttUse <= 1'b1;
    wrChk('h43, 1);
    measure(1'b1, 1'b0, tickQ[1]);
    tally_and_finish();
  end
endmodule
